// ===== verilog/pcfg_top.sv
// Register bank for PLL2 pump/detector controls and the oscillator output path.
// Assumes an AXI4-Lite master on aclk; one write and one read in flight at most.
//
// What this block does
// [RULE1] Low nibble of pump register is the linear pump current code.
// [RULE2] Detector register bit 4 enables up, bit 3 enables down.
// [RULE3] Bit 2 forces pump up, bit 1 forces pump down.
// [RULE4] Software never sets both force bits together.
// [RULE5] Path divider codes 0..3 in bits 2:1 divide by 1,2,4,8.
// [RULE6] Path bit 0 enables divider and internal path, not driver.
// [RULE7] Driver bits 5:4 pick CML, ECL, LVDS or CMOS mode.
// [RULE8] Driver bits 2:1 pick CML termination none, 100, reserved, 50.
// [RULE9] Driver bit 0 enables that driver.
// [RULE10] Reserved bits are plain storage without effect.
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module pcfg_top (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address.
   input wire logic [9:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data.
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response.
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address.
   input wire logic [9:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data.
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // PLL2 pump and detector controls.
   output logic [3:0] pump_current_code,
   output logic detector_up_enable,
   output logic detector_down_enable,
   output logic force_pump_up,
   output logic force_pump_down,
   output logic detector_polarity_neg,
   // Oscillator output path.
   output logic osc_output_path_enable,
   output logic [3:0] osc_output_div_ratio,
   // Oscillator output drivers.
   output logic osc_output_drv0_enable,
   output logic [1:0] osc_output_drv0_mode,
   output logic osc_output_drv0_term_100,
   output logic osc_output_drv0_term_50,
   output logic osc_output_drv1_enable,
   output logic [1:0] osc_output_drv1_mode,
   output logic osc_output_drv1_term_100,
   output logic osc_output_drv1_term_50
);

   // Maps a byte address to a register slot; returns NUM_REGS when unmapped.
   function automatic logic [2:0] reg_slot(input logic [9:0] addr);
      logic [7:0] idx;
      idx = addr[9:2];
      reg_slot = 3'(pcfg_pkg::NUM_REGS);
      if (addr[1:0] == 2'h0) begin
         if (idx == pcfg_pkg::IDX_PUMP_CURRENT) begin
            reg_slot = 3'h0;
         end else if (idx == pcfg_pkg::IDX_DETECTOR_CONTROL) begin
            reg_slot = 3'h1;
         end else if (idx == pcfg_pkg::IDX_PATH_CONTROL) begin
            reg_slot = 3'h2;
         end else if (idx == pcfg_pkg::IDX_DRIVER0_CONTROL) begin
            reg_slot = 3'h3;
         end else if (idx == pcfg_pkg::IDX_DRIVER1_CONTROL) begin
            reg_slot = 3'h4;
         end
      end
   endfunction : reg_slot

   // Register storage and write channel state.
   logic [7:0] regs_q [0:4];
   logic [7:0] regs_d [0:4];
   logic aw_held_q, aw_held_d, w_held_q, w_held_d;
   logic [9:0] awaddr_q, awaddr_d;
   logic [7:0] wbyte_q, wbyte_d;
   logic wstrb0_q, wstrb0_d;
   logic bvalid_q, bvalid_d;
   logic [1:0] bresp_q, bresp_d;
   logic [2:0] wslot;

   // Write path: take address and data in either order, answer once both are held.
   always_comb begin
      aw_held_d = aw_held_q;
      w_held_d = w_held_q;
      awaddr_d = awaddr_q;
      wbyte_d = wbyte_q;
      wstrb0_d = wstrb0_q;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      for (int i = 0; i < pcfg_pkg::NUM_REGS; i++) begin
         regs_d[i] = regs_q[i];
      end
      wslot = reg_slot(awaddr_q);
      if (s_axi_awvalid && !aw_held_q && !bvalid_q) begin
         aw_held_d = 1'b1;
         awaddr_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held_q && !bvalid_q) begin
         w_held_d = 1'b1;
         wbyte_d = s_axi_wdata[7:0];
         wstrb0_d = s_axi_wstrb[0];
      end
      if (aw_held_q && w_held_q) begin
         // [RULE10] whole byte stored
         if (wslot < 3'(pcfg_pkg::NUM_REGS)) begin
            if (wstrb0_q) begin
               regs_d[wslot] = wbyte_q;
            end
            bresp_d = pcfg_pkg::RESP_OKAY;
         end else begin
            bresp_d = pcfg_pkg::RESP_SLVERR;
         end
         bvalid_d = 1'b1;
         aw_held_d = 1'b0;
         w_held_d = 1'b0;
      end
      if (bvalid_q && s_axi_bready) begin
         bvalid_d = 1'b0;
      end
   end

   // Register the write path; stored bytes reset to zero, all outputs disabled.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         awaddr_q <= 10'h000;
         wbyte_q <= 8'h00;
         wstrb0_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= pcfg_pkg::RESP_OKAY;
         for (int i = 0; i < pcfg_pkg::NUM_REGS; i++) begin
            regs_q[i] <= pcfg_pkg::RST_REG;
         end
      end else begin
         aw_held_q <= aw_held_d;
         w_held_q <= w_held_d;
         awaddr_q <= awaddr_d;
         wbyte_q <= wbyte_d;
         wstrb0_q <= wstrb0_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         for (int i = 0; i < pcfg_pkg::NUM_REGS; i++) begin
            regs_q[i] <= regs_d[i];
         end
      end
   end

   assign s_axi_awready = !aw_held_q && !bvalid_q;
   assign s_axi_wready = !w_held_q && !bvalid_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;

   // Read channel state.
   logic rvalid_q, rvalid_d;
   logic [31:0] rdata_q, rdata_d;
   logic [1:0] rresp_q, rresp_d;
   logic [2:0] rslot;

   // Read path: one cycle from address to data; bits above the byte read zero.
   always_comb begin
      rvalid_d = rvalid_q;
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      rslot = reg_slot(s_axi_araddr);
      if (s_axi_arvalid && !rvalid_q) begin
         rvalid_d = 1'b1;
         if (rslot < 3'(pcfg_pkg::NUM_REGS)) begin
            rdata_d = {24'h000000, regs_q[rslot]};
            rresp_d = pcfg_pkg::RESP_OKAY;
         end else begin
            rdata_d = 32'h00000000;
            rresp_d = pcfg_pkg::RESP_SLVERR;
         end
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_d = 1'b0;
      end
   end

   // Register the read path.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h00000000;
         rresp_q <= pcfg_pkg::RESP_OKAY;
      end else begin
         rvalid_q <= rvalid_d;
         rdata_q <= rdata_d;
         rresp_q <= rresp_d;
      end
   end

   assign s_axi_arready = !rvalid_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

   // Decoded analog controls, one flop stage behind the stored bytes.
   logic [3:0] pump_d, pump_q;
   logic up_en_d, up_en_q, dn_en_d, dn_en_q;
   logic fup_d, fup_q, fdn_d, fdn_q, pol_d, pol_q;
   logic path_en_d, path_en_q;
   logic [3:0] ratio_d, ratio_q;
   logic [7:0] det;

   // Decode pump, detector and path fields; reserved bits feed nothing.
   always_comb begin
      det = regs_q[1];
      // [RULE1] pump current code
      pump_d = regs_q[0][pcfg_pkg::PUMP_CODE_LSB +: pcfg_pkg::PUMP_CODE_W];
      // [RULE2] detector up/down enables
      up_en_d = det[pcfg_pkg::DET_UP_EN_BIT];
      dn_en_d = det[pcfg_pkg::DET_DN_EN_BIT];
      // [RULE3] charge pump force bits
      fup_d = det[pcfg_pkg::DET_FORCE_UP_BIT];
      fdn_d = det[pcfg_pkg::DET_FORCE_DN_BIT];
      // [RULE4] both set: neither wins
      if (fup_d && fdn_d) begin
         fup_d = 1'b0;
         fdn_d = 1'b0;
      end
      pol_d = det[pcfg_pkg::DET_POLARITY_BIT];
      // [RULE6] path enable bit
      path_en_d = regs_q[2][pcfg_pkg::PATH_EN_BIT];
      // [RULE5] power-of-two divide ratio
      case (regs_q[2][pcfg_pkg::PATH_DIV_LSB +: 2])
         2'h0: ratio_d = 4'h1;
         2'h1: ratio_d = 4'h2;
         2'h2: ratio_d = 4'h4;
         2'h3: ratio_d = 4'h8;
         default: ratio_d = 4'h1;
      endcase
   end

   // Register the decoded controls.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pump_q <= 4'h0;
         up_en_q <= 1'b0;
         dn_en_q <= 1'b0;
         fup_q <= 1'b0;
         fdn_q <= 1'b0;
         pol_q <= 1'b0;
         path_en_q <= 1'b0;
         ratio_q <= 4'h1;
      end else begin
         pump_q <= pump_d;
         up_en_q <= up_en_d;
         dn_en_q <= dn_en_d;
         fup_q <= fup_d;
         fdn_q <= fdn_d;
         pol_q <= pol_d;
         path_en_q <= path_en_d;
         ratio_q <= ratio_d;
      end
   end

   assign pump_current_code = pump_q;
   assign detector_up_enable = up_en_q;
   assign detector_down_enable = dn_en_q;
   assign force_pump_up = fup_q;
   assign force_pump_down = fdn_q;
   assign detector_polarity_neg = pol_q;
   assign osc_output_path_enable = path_en_q;
   assign osc_output_div_ratio = ratio_q;

   // Two identical driver decoders, one per control byte.
   pcfg_driver u_drv0 (
      .aclk(aclk),
      .aresetn(aresetn),
      .ctrl(regs_q[3]),
      .drv_enable(osc_output_drv0_enable),
      .drv_mode(osc_output_drv0_mode),
      .drv_term_100(osc_output_drv0_term_100),
      .drv_term_50(osc_output_drv0_term_50)
   );

   pcfg_driver u_drv1 (
      .aclk(aclk),
      .aresetn(aresetn),
      .ctrl(regs_q[4]),
      .drv_enable(osc_output_drv1_enable),
      .drv_mode(osc_output_drv1_mode),
      .drv_term_100(osc_output_drv1_term_100),
      .drv_term_50(osc_output_drv1_term_50)
   );
endmodule : pcfg_top
`default_nettype wire

// ===== verilog/pcfg_pkg.sv
// Package for the PLL2 detector and oscillator output configuration bank.
// Assumes an AXI4-Lite slave with 32-bit data; each 8-bit register sits in one word.
package pcfg_pkg;
   // Printed offsets are not all multiples of four, so they are register indices.
   localparam logic [7:0] IDX_PUMP_CURRENT = 8'h37;
   localparam logic [7:0] IDX_DETECTOR_CONTROL = 8'h38;
   localparam logic [7:0] IDX_PATH_CONTROL = 8'h39;
   localparam logic [7:0] IDX_DRIVER0_CONTROL = 8'h3A;
   localparam logic [7:0] IDX_DRIVER1_CONTROL = 8'h3B;
   localparam int ADDR_W = 10;
   localparam int NUM_REGS = 5;
   // Reset values (none documented; all zero, everything disabled).
   localparam logic [7:0] RST_REG = 8'h00;
   // Field positions.
   localparam int PUMP_CODE_LSB = 0;
   localparam int PUMP_CODE_W = 4;
   localparam int DET_UP_EN_BIT = 4;
   localparam int DET_DN_EN_BIT = 3;
   localparam int DET_FORCE_UP_BIT = 2;
   localparam int DET_FORCE_DN_BIT = 1;
   localparam int DET_POLARITY_BIT = 0;
   localparam int PATH_DIV_LSB = 1;
   localparam int PATH_EN_BIT = 0;
   localparam int DRV_MODE_LSB = 4;
   localparam int DRV_TERM_LSB = 1;
   localparam int DRV_EN_BIT = 0;
   // Driver modes and termination codes.
   typedef enum logic [1:0] {
      PCFG_MODE_CML = 2'h0,
      PCFG_MODE_ECL = 2'h1,
      PCFG_MODE_LVDS = 2'h2,
      PCFG_MODE_CMOS = 2'h3
   } pcfg_mode_type;
   localparam logic [1:0] TERM_NONE = 2'h0;
   localparam logic [1:0] TERM_100 = 2'h1;
   localparam logic [1:0] TERM_RSVD = 2'h2;
   localparam logic [1:0] TERM_50 = 2'h3;
   // AXI responses.
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : pcfg_pkg

// ===== verilog/pcfg_driver.sv
// One oscillator output driver decoder.
// Assumes its control byte is a registered value on the same clock.
`timescale 1ns/1ps
`default_nettype none
module pcfg_driver (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Control byte.
   input wire logic [7:0] ctrl,
   // Decoded driver controls.
   output logic drv_enable,
   output logic [1:0] drv_mode,
   output logic drv_term_100,
   output logic drv_term_50
);
   logic en_d, en_q, t100_d, t100_q, t50_d, t50_q;
   logic [1:0] mode_d, mode_q;
   logic [1:0] term;

   // Decode mode, termination and enable; termination only applies in CML.
   always_comb begin
      term = ctrl[pcfg_pkg::DRV_TERM_LSB +: 2];
      // [RULE7] driver mode select
      mode_d = ctrl[pcfg_pkg::DRV_MODE_LSB +: 2];
      // [RULE8] CML termination select
      t100_d = (mode_d == pcfg_pkg::PCFG_MODE_CML) && (term == pcfg_pkg::TERM_100);
      t50_d = (mode_d == pcfg_pkg::PCFG_MODE_CML) && (term == pcfg_pkg::TERM_50);
      // [RULE9] driver enable bit
      en_d = ctrl[pcfg_pkg::DRV_EN_BIT];
   end

   // Register the decoded controls so outputs come from flip-flops.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         en_q <= 1'b0;
         mode_q <= 2'h0;
         t100_q <= 1'b0;
         t50_q <= 1'b0;
      end else begin
         en_q <= en_d;
         mode_q <= mode_d;
         t100_q <= t100_d;
         t50_q <= t50_d;
      end
   end

   assign drv_enable = en_q;
   assign drv_mode = mode_q;
   assign drv_term_100 = t100_q;
   assign drv_term_50 = t50_q;
endmodule : pcfg_driver
`default_nettype wire

// ===== dv/pcfg_assertions.sv
// Port checker for the PLL2 and oscillator output register bank.
// Assumes it is bound to pcfg_top and sees nothing but its ports.
`timescale 1ns/1ps
`default_nettype none
module pcfg_assertions (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Bus handshakes.
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   // Decoded controls.
   input wire logic [3:0] pump_current_code,
   input wire logic force_pump_up,
   input wire logic force_pump_down,
   input wire logic [3:0] osc_output_div_ratio,
   input wire logic [1:0] osc_output_drv0_mode,
   input wire logic osc_output_drv0_term_100,
   input wire logic osc_output_drv0_term_50
);
   // One domain, so clock and reset are given once for every property.
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // Decoded outputs and bus answers must follow their causes.
   a_force_excl: assert property (!(force_pump_up && force_pump_down))
      else $error("Both pump force outputs high.");
   a_div_power: assert property (osc_output_div_ratio inside {4'h1, 4'h2, 4'h4, 4'h8})
      else $error("Divider ratio is not a power of two.");
   a_term_cml: assert property (osc_output_drv0_term_100 || osc_output_drv0_term_50
      |-> osc_output_drv0_mode == 2'h0) else $error("Termination outside CML mode.");
   a_term_excl: assert property (!(osc_output_drv0_term_100 && osc_output_drv0_term_50))
      else $error("Both termination outputs high.");
   a_pump_cause: assert property ($changed(pump_current_code)
      |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2)) else $error("Pump code moved unwritten.");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("Write response dropped.");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("Read data dropped.");
   a_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("Read answer late.");
   a_write_lat: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:3] s_axi_bvalid) else $error("Write answer late.");
   a_rdata_pad: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("Upper read data not zero.");
   a_aw_busy: assert property (s_axi_bvalid |-> !s_axi_awready)
      else $error("Write address taken while answering.");

   // Main scenarios seen.
   c_write: cover property (s_axi_bvalid && s_axi_bready);
   c_read: cover property (s_axi_rvalid && s_axi_rready);
   c_force: cover property (force_pump_up);
   c_term50: cover property (osc_output_drv0_term_50);
endmodule : pcfg_assertions

bind pcfg_top pcfg_assertions chk_u (.*);
`default_nettype wire

// ===== dv/testbench.sv
// Self-checking bench for the PLL2 and oscillator output register bank.
// Assumes pcfg_top with its checker bound; drives AXI4-Lite on aclk.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   // Master signals, all valued at time zero.
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [9:0] s_axi_awaddr = 10'h000;
   logic [9:0] s_axi_araddr = 10'h000;
   logic [2:0] s_axi_awprot = 3'h0;
   logic [2:0] s_axi_arprot = 3'h0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0;
   // Design outputs.
   wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire logic [1:0] s_axi_bresp, s_axi_rresp, osc_output_drv0_mode, osc_output_drv1_mode;
   wire logic [31:0] s_axi_rdata;
   wire logic [3:0] pump_current_code, osc_output_div_ratio;
   wire logic detector_up_enable, detector_down_enable, force_pump_up, force_pump_down;
   wire logic detector_polarity_neg, osc_output_path_enable;
   wire logic osc_output_drv0_enable, osc_output_drv0_term_100, osc_output_drv0_term_50;
   wire logic osc_output_drv1_enable, osc_output_drv1_term_100, osc_output_drv1_term_50;
   // Counters and the bench's own copy of the five stored bytes.
   int mismatches = 0;
   int cmp_count = 0;
   logic [7:0] regs [5] = '{default: 8'h00};
   logic [1:0] resp;
   logic [31:0] rdat;
   wire logic [23:0] outs = {pump_current_code, detector_up_enable, detector_down_enable,
      force_pump_up, force_pump_down, detector_polarity_neg, osc_output_path_enable,
      osc_output_div_ratio, osc_output_drv0_enable, osc_output_drv0_mode,
      osc_output_drv0_term_100, osc_output_drv0_term_50, osc_output_drv1_enable,
      osc_output_drv1_mode, osc_output_drv1_term_100, osc_output_drv1_term_50};

   // The 5 ns clock.
   always #2.5 aclk = ~aclk;

   pcfg_top dut_u (.*);

   // Expected driver outputs; termination only counts in CML mode.
   function automatic logic [4:0] drv_exp(input logic [7:0] x);
      return {x[0], x[5:4], x[5:4] == 2'h0 && x[2:1] == 2'h1, x[5:4] == 2'h0 && x[2:1] == 2'h3};
   endfunction : drv_exp

   // Expected decoded outputs; a forbidden force pair gives neither force.
   function automatic logic [23:0] exp_outs();
      logic [7:0] d;
      d = regs[1];
      return {regs[0][3:0], d[4], d[3], d[2] & ~d[1], d[1] & ~d[2], d[0], regs[2][0],
         4'h1 << regs[2][2:1], drv_exp(regs[3]), drv_exp(regs[4])};
   endfunction : exp_outs

   task automatic stop_test();
      if (mismatches == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : stop_test

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %0t %s", $time, msg);
      end
   endtask : check

   task automatic hang();
      mismatches++;
      $display("CHECK FAILED %0t bus wait timed out", $time);
      stop_test();
   endtask : hang

   // Write cycle; one idle edge at the end so no signal is driven twice at once.
   task automatic axi_write(input logic [9:0] a, input logic [31:0] d, input logic [3:0] s);
      int n;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      if (n == 40) hang();
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask : axi_write

   // Read cycle, same pattern.
   task automatic axi_read(input logic [9:0] a);
      int n;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      if (n == 40) hang();
      resp = s_axi_rresp;
      rdat = s_axi_rdata;
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask : axi_read

   function automatic logic [9:0] adr(input logic [2:0] k);
      return {8'(pcfg_pkg::IDX_PUMP_CURRENT + k), 2'b00};
   endfunction : adr

   // Write a byte, then compare response and decoded outputs.
   task automatic wr(input logic [2:0] k, input logic [7:0] v);
      axi_write(adr(k), {24'h0, v}, 4'hF);
      regs[k] = v;
      check(resp, pcfg_pkg::RESP_OKAY, "write response");
      @(posedge aclk);
      check(outs, exp_outs(), "decoded outputs");
   endtask : wr

   task automatic rd(input logic [2:0] k);
      axi_read(adr(k));
      check(resp, pcfg_pkg::RESP_OKAY, "read response");
      check(rdat, {24'h0, regs[k]}, "read back");
   endtask : rd

   task automatic t_reset();
      for (int k = 0; k < 5; k++) rd(3'(k));
      check(outs, exp_outs(), "outputs after reset");
   endtask : t_reset

   task automatic t_pump();
      wr(3'd0, 8'hF5);
      rd(3'd0);
      wr(3'd0, 8'h0F);
   endtask : t_pump

   task automatic t_detector();
      logic [7:0] tbl [8] = '{8'h10, 8'h08, 8'h04, 8'h02, 8'h06, 8'h01, 8'hE0, 8'h1E};
      for (int i = 0; i < 8; i++) begin
         wr(3'd1, tbl[i]);
         rd(3'd1);
      end
   endtask : t_detector

   task automatic t_path();
      for (int c = 0; c < 4; c++) begin
         wr(3'd2, {5'h1F, 2'(c), 1'b1});
         wr(3'd2, {5'h00, 2'(c), 1'b0});
      end
   endtask : t_path

   task automatic t_drivers();
      for (int d = 3; d < 5; d++) begin
         for (int m = 0; m < 16; m++) wr(3'(d), {2'h3, 2'(m >> 2), 1'b1, 2'(m), 1'b1});
         wr(3'(d), 8'h30);
         rd(3'(d));
      end
   endtask : t_drivers

   // Unmapped, unaligned and strobe-less writes change nothing.
   task automatic t_refused();
      axi_write(10'h0F0, 32'h0000_0055, 4'hF);
      check(resp, pcfg_pkg::RESP_SLVERR, "unmapped write");
      axi_write(10'h0DD, 32'h0000_0055, 4'hF);
      check(resp, pcfg_pkg::RESP_SLVERR, "unaligned write");
      axi_read(10'h0F0);
      check(resp, pcfg_pkg::RESP_SLVERR, "unmapped read");
      check(rdat, 32'h0, "unmapped data");
      axi_write(adr(3'd0), 32'h0000_00AA, 4'h0);
      check(resp, pcfg_pkg::RESP_OKAY, "strobe-less write");
      rd(3'd0);
      check(outs, exp_outs(), "outputs unchanged");
   endtask : t_refused

   // Reset for two cycles, then the scenarios.
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_reset();
      t_pump();
      t_detector();
      t_path();
      t_drivers();
      t_refused();
      stop_test();
   end
endmodule : testbench
`default_nettype wire
